// file: hw/cct_defs.vh
// Timing, threshold and register constants for the charge-cycle sequencer
`ifndef CCT_DEFS_VH
`define CCT_DEFS_VH
`define CCT_CLK_MHZ 100
`define CCT_TICK_US 1
`define CCT_TIMER_W 32
`define CCT_CODE_W 12
`define CCT_SAMPLE_S 34
`define CCT_MAXCELL_WAIT_MS 1500
`define CCT_HOLDOFF_S 137
`define CCT_TOPOFF_S 1800
`define CCT_GATE_ON_US 260
`define CCT_GATE_OFF_US 1820
`define CCT_TRICKLE_PERIOD_US 133120
`define CCT_PEAK_WIN_US 9170
`define CCT_NDV_WIN_US 18180
`define CCT_TEMP_WIN_US 18180
`define CCT_PEAK_COUNT 32
`define CCT_NDV_COUNT 16
`define CCT_TEMP_COUNT 16
`define CCT_NDV_DROP_MV 12
`define CCT_PEAK_DROP_MV 6
`define CCT_TEMP_DROP_MV 16
`define CCT_ADR_W 8
`define CCT_REG_CTRL 8'h00
`define CCT_REG_STATUS 8'h04
`define CCT_REG_VMAX 8'h08
`define CCT_REG_TEMP 8'h0C
`define CCT_CTRL_RESTART 0
`define CCT_CTRL_TOPOFF_EN 1
`define CCT_CTRL_RESET 32'h00000002
`define CCT_SYNC_IDLE 4'hF
`endif

// file: hw/cct_sync.v
// Three-stage pin synchroniser; output follows once stages two and three agree
module cct_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] IDLE = {WIDTH{1'b1}}
) (
    input wire mclk,
    input wire reset_n,
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] level
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    integer i;

    always @(posedge mclk) begin
        if (!reset_n) begin
            stage1 <= IDLE;
            stage2 <= IDLE;
            stage3 <= IDLE;
            level <= IDLE;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2[i] == stage3[i])
                    level[i] <= stage3[i];
            end
        end
    end
endmodule

// file: hw/cct_average.v
// Averages 16 or 32 evenly spaced measurements into one sample
`include "cct_defs.vh"
module cct_average #(
    parameter CODE_W = 12
) (
    input wire mclk,
    input wire reset_n,
    input wire start,
    input wire us_tick,
    input wire long_mode,
    input wire [15:0] interval_us,
    input wire [CODE_W-1:0] code,
    output reg [CODE_W-1:0] avg,
    output reg done
);
    localparam [5:0] LONG_N = `CCT_PEAK_COUNT;
    localparam [5:0] SHORT_N = `CCT_NDV_COUNT;
    reg busy;
    reg [15:0] icnt;
    reg [5:0] n;
    reg [CODE_W+4:0] acc;
    wire [5:0] target = long_mode ? LONG_N : SHORT_N;
    wire [CODE_W+4:0] sum = acc + {5'h00, code};

    always @(posedge mclk) begin
        if (!reset_n) begin
            busy <= 1'b0;
            icnt <= 16'h0000;
            n <= 6'h00;
            acc <= {(CODE_W+5){1'b0}};
            avg <= {CODE_W{1'b0}};
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy <= 1'b1;
                icnt <= 16'h0000;
                n <= 6'h00;
                acc <= {(CODE_W+5){1'b0}};
            end else if (busy && us_tick) begin
                if (icnt == interval_us - 16'h0001) begin
                    icnt <= 16'h0000;
                    acc <= sum;
                    n <= n + 6'h01;
                    if (n == target - 6'h01) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        // Counts are powers of two, so the divide is a shift
                        avg <= long_mode ? sum[CODE_W+4:5] : sum[CODE_W+3:4];
                    end
                end else begin
                    icnt <= icnt + 16'h0001;
                end
            end
        end
    end
endmodule

// file: hw/cct_charge_ctrl.v
// Charge-cycle sequencer with qualification, hold-off and termination tests
`include "cct_defs.vh"

// Functional notes
// (R01) Cell and temperature codes are sense-referenced
// (R02) Discharge until below end-discharge, then restart
// (R03) Discharge request idles high via pull-up
// (R04) Request falling edge starts discharge anywhere
// (R05) Request held low: cycles begin discharging
// (R06) Power-up, max-cell fall, hold release restart
// (R07) Fast charge needs voltage and temperature valid
// (R08) Temperature valid between high and low fault
// (R09) Failed qualification waits in pending, unlimited
// (R10) Pending: top-off eighth rate, then trickle
// (R11) Voltage too high in qualification: absent
// (R12) One averaged cell sample every 34 s
// (R13) Negative delta: 12 mV below maximum ends
// (R14) Peak detect: 6 mV below maximum ends
// (R15) Voltage tests only between 0.4 and 0.8
// (R16) Select pin: low off, float ndv, high peak
// (R17) Average 32 peak, 16 negative-delta measurements
// (R18) Windows 9.17 ms and 18.18 ms
// (R19) Hold-off masks negative delta and slope tests
// (R20) Hold-off gate 260 us on, 1820 us off
// (R21) Temperature 16 mV fall over two samples ends
// (R22) Temperature sample averages 16 over 18.18 ms
// (R23) Hold low: outputs released, low power
// (R24) Gate high passes current, low blocks
// (R25) Above max cell: stop, then complete or absent
// (R26) Comparisons and codes are synchronous inputs
// (R27) Running maximum cleared at each fast start
module cct_charge_ctrl #(
    parameter CODE_W = `CCT_CODE_W,
    parameter [31:0] SAMPLE_US = `CCT_SAMPLE_S * 1000000,
    parameter [31:0] HOLDOFF_US = `CCT_HOLDOFF_S * 1000000,
    parameter [31:0] TOPOFF_US = `CCT_TOPOFF_S * 1000000,
    parameter [31:0] MAXCELL_WAIT_US = `CCT_MAXCELL_WAIT_MS * 1000,
    parameter [31:0] TRICKLE_PERIOD_US = `CCT_TRICKLE_PERIOD_US
) (
    input wire mclk,
    input wire reset_n,
    input wire discharge_request_n,
    input wire charge_hold_n,
    input wire voltage_term_select_high,
    input wire voltage_term_select_low,
    input wire cell_above_max,
    input wire cell_above_end_discharge,
    input wire temp_above_high_fault,
    input wire temp_below_low_fault,
    input wire temp_above_cutoff,
    input wire [CODE_W-1:0] cell_code,
    input wire [CODE_W-1:0] temp_code,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`CCT_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg current_gate,
    output reg current_gate_oe,
    output reg discharge_drive,
    output reg discharge_drive_oe,
    output reg discharge_pullup_en,
    output reg low_power,
    output reg [7:0] charge_state
);
    localparam [7:0] ST_DISCHARGE = 8'h01;
    localparam [7:0] ST_QUALIFY = 8'h02;
    localparam [7:0] ST_TOPOFF = 8'h04;
    localparam [7:0] ST_TRICKLE = 8'h08;
    localparam [7:0] ST_FAST = 8'h10;
    localparam [7:0] ST_MAXCELL = 8'h20;
    localparam [7:0] ST_COMPLETE = 8'h40;
    localparam [7:0] ST_ABSENT = 8'h80;
    localparam [7:0] CYC_PER_US = `CCT_CLK_MHZ * `CCT_TICK_US;
    localparam [15:0] PEAK_STEP_US = `CCT_PEAK_WIN_US / `CCT_PEAK_COUNT;
    localparam [15:0] NDV_STEP_US = `CCT_NDV_WIN_US / `CCT_NDV_COUNT;
    localparam [15:0] TEMP_STEP_US = `CCT_TEMP_WIN_US / `CCT_TEMP_COUNT;
    localparam [31:0] GATE_ON_US = `CCT_GATE_ON_US;
    localparam [31:0] GATE_PERIOD_US = `CCT_GATE_ON_US + `CCT_GATE_OFF_US;
    localparam [CODE_W-1:0] NDV_DROP = `CCT_NDV_DROP_MV;
    localparam [CODE_W-1:0] PEAK_DROP = `CCT_PEAK_DROP_MV;
    localparam [CODE_W-1:0] TEMP_DROP = `CCT_TEMP_DROP_MV;

    // True when the new value sits at least drop below the old one
    function fell_by;
        input [CODE_W-1:0] old_v;
        input [CODE_W-1:0] new_v;
        input [CODE_W-1:0] drop;
        begin
            fell_by = ({1'b0, old_v} >= ({1'b0, new_v} + {1'b0, drop}));
        end
    endfunction

    wire [3:0] pin_level;
    reg [3:0] pin_prev;
    reg [7:0] prescale;
    reg us_tick;
    reg [7:0] state;
    reg [7:0] next_state;
    reg [31:0] state_us;
    reg [31:0] pulse_us;
    reg [31:0] sample_us;
    reg [31:0] holdoff_us;
    reg holdoff;
    reg power_up;
    reg max_prev;
    reg sample_start;
    reg [CODE_W-1:0] vmax;
    reg vmax_valid;
    reg [CODE_W-1:0] temp_old1;
    reg [CODE_W-1:0] temp_old2;
    reg [1:0] temp_count;
    reg term_hit;
    reg [31:0] ctrl;
    reg next_gate;
    wire [CODE_W-1:0] cell_avg;
    wire cell_done;
    wire [CODE_W-1:0] temp_avg;
    wire temp_done;

    // Bit order: request, hold, select high, select low
    cct_sync #(.WIDTH(4), .IDLE(`CCT_SYNC_IDLE)) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .pin({discharge_request_n, charge_hold_n,
              voltage_term_select_high, voltage_term_select_low}),
        .level(pin_level)
    );

    wire req_n = pin_level[3];
    wire hold_n = pin_level[2];
    wire sel_peak = pin_level[1];
    wire sel_ndv = ~pin_level[1] & ~pin_level[0];
    wire req_fell = pin_prev[3] & ~req_n; // [R04]
    wire hold_rose = ~pin_prev[2] & hold_n; // [R06]
    wire max_fell = max_prev & ~cell_above_max; // [R06]
    wire volt_ok = cell_above_end_discharge & ~cell_above_max; // [R07]
    wire temp_ok = temp_above_high_fault & temp_below_low_fault; // [R08]
    wire qual_ok = volt_ok & temp_ok; // [R07]
    wire sw_restart = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0]
        & (wb_adr_i == `CCT_REG_CTRL) & wb_dat_i[`CCT_CTRL_RESTART];
    wire new_cycle = power_up | hold_rose | sw_restart
        | (max_fell & (state != ST_MAXCELL));
    wire [7:0] first_state = req_n ? ST_QUALIFY : ST_DISCHARGE; // [R05]
    wire charging = (state == ST_TOPOFF) | (state == ST_TRICKLE)
        | (state == ST_FAST) | (state == ST_COMPLETE);
    wire [31:0] pulse_period = (state == ST_TRICKLE) ?
        TRICKLE_PERIOD_US : GATE_PERIOD_US;

    // Timing derives from mclk only; comparator inputs are used as is [R26]
    always @(posedge mclk) begin
        if (!reset_n) begin
            prescale <= 8'h00;
            us_tick <= 1'b0;
        end else if (prescale == CYC_PER_US - 8'h01) begin
            prescale <= 8'h00;
            us_tick <= 1'b1;
        end else begin
            prescale <= prescale + 8'h01;
            us_tick <= 1'b0;
        end
    end

    always @* begin
        next_state = state;
        if (!hold_n) begin
            next_state = state;
        end else if (req_fell) begin
            next_state = ST_DISCHARGE; // [R04]
        end else if (new_cycle) begin
            next_state = first_state; // [R06] [R05]
        end else begin
            case (state)
                ST_DISCHARGE: begin
                    if (!cell_above_end_discharge)
                        next_state = ST_QUALIFY; // [R02]
                end
                ST_QUALIFY: begin
                    if (cell_above_max)
                        next_state = ST_ABSENT; // [R11]
                    else if (qual_ok)
                        next_state = ST_FAST; // [R07]
                    else if (ctrl[`CCT_CTRL_TOPOFF_EN])
                        next_state = ST_TOPOFF; // [R09]
                    else
                        next_state = ST_TRICKLE; // [R09]
                end
                ST_TOPOFF, ST_TRICKLE: begin
                    if (cell_above_max)
                        next_state = ST_MAXCELL; // [R25]
                    else if (qual_ok)
                        next_state = ST_FAST; // [R09]
                    else if (state == ST_TOPOFF && state_us >= TOPOFF_US)
                        next_state = ST_TRICKLE; // [R10]
                end
                ST_FAST: begin
                    if (cell_above_max)
                        next_state = ST_MAXCELL; // [R25]
                    else if (!temp_above_cutoff || !temp_below_low_fault)
                        next_state = ST_COMPLETE;
                    else if (term_hit)
                        next_state = ST_COMPLETE; // [R13] [R14] [R21]
                end
                ST_MAXCELL: begin
                    if (!cell_above_max)
                        next_state = ST_COMPLETE; // [R25]
                    else if (state_us >= MAXCELL_WAIT_US)
                        next_state = ST_ABSENT; // [R25]
                end
                ST_COMPLETE: begin
                    if (cell_above_max)
                        next_state = ST_MAXCELL; // [R25]
                end
                ST_ABSENT: next_state = ST_ABSENT; // [R11]
                default: next_state = first_state;
            endcase
        end
    end

    // Gate pattern: eighth rate for hold-off and top-off, sparse for trickle
    always @* begin
        next_gate = 1'b0;
        case (state)
            ST_FAST: next_gate = holdoff ? (pulse_us < GATE_ON_US) : 1'b1;
            ST_TOPOFF: next_gate = (pulse_us < GATE_ON_US); // [R10]
            ST_TRICKLE: next_gate = (pulse_us < GATE_ON_US); // [R10]
            default: next_gate = 1'b0;
        endcase
        if (cell_above_max || !hold_n)
            next_gate = 1'b0; // [R25] [R23]
        if (state == ST_FAST && holdoff && hold_n && !cell_above_max)
            next_gate = (pulse_us < GATE_ON_US); // [R20]
    end

    always @(posedge mclk) begin
        if (!reset_n) begin
            state <= ST_QUALIFY;
            pin_prev <= `CCT_SYNC_IDLE;
            max_prev <= 1'b0;
            power_up <= 1'b1;
            state_us <= 32'h00000000;
            pulse_us <= 32'h00000000;
        end else begin
            pin_prev <= pin_level;
            max_prev <= cell_above_max;
            // Power-up counts as a cycle start once, after the reset release
            power_up <= 1'b0; // [R06]
            state <= next_state;
            if (next_state != state) begin
                state_us <= 32'h00000000;
                pulse_us <= 32'h00000000;
            end else if (us_tick && hold_n) begin
                if (state_us != 32'hFFFFFFFF)
                    state_us <= state_us + 32'h00000001;
                if (pulse_us >= pulse_period - 32'h00000001)
                    pulse_us <= 32'h00000000;
                else
                    pulse_us <= pulse_us + 32'h00000001;
            end
        end
    end

    // Hold-off and sample timers only run during fast charge
    always @(posedge mclk) begin
        if (!reset_n) begin
            holdoff <= 1'b0;
            holdoff_us <= 32'h00000000;
            sample_us <= 32'h00000000;
            sample_start <= 1'b0;
        end else begin
            sample_start <= 1'b0;
            if (state != ST_FAST) begin
                holdoff <= 1'b1; // [R19]
                holdoff_us <= 32'h00000000;
                sample_us <= 32'h00000000;
            end else if (us_tick && hold_n) begin
                if (holdoff_us >= HOLDOFF_US - 32'h00000001)
                    holdoff <= 1'b0;
                else
                    holdoff_us <= holdoff_us + 32'h00000001;
                if (sample_us >= SAMPLE_US - 32'h00000001) begin
                    sample_us <= 32'h00000000;
                    sample_start <= 1'b1; // [R12] [R21]
                end else begin
                    sample_us <= sample_us + 32'h00000001;
                end
            end
        end
    end

    cct_average #(.CODE_W(CODE_W)) u_cell_avg (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(sample_start),
        .us_tick(us_tick),
        .long_mode(sel_peak), // [R17]
        .interval_us(sel_peak ? PEAK_STEP_US : NDV_STEP_US), // [R18]
        .code(cell_code), // [R01]
        .avg(cell_avg),
        .done(cell_done)
    );

    cct_average #(.CODE_W(CODE_W)) u_temp_avg (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(sample_start),
        .us_tick(us_tick),
        .long_mode(1'b0), // [R22]
        .interval_us(TEMP_STEP_US), // [R22]
        .code(temp_code), // [R01]
        .avg(temp_avg),
        .done(temp_done)
    );

    // Termination tests; an average that completes outside fast charge is ignored
    always @(posedge mclk) begin
        if (!reset_n) begin
            vmax <= {CODE_W{1'b0}};
            vmax_valid <= 1'b0;
            temp_old1 <= {CODE_W{1'b0}};
            temp_old2 <= {CODE_W{1'b0}};
            temp_count <= 2'b00;
            term_hit <= 1'b0;
        end else if (state != ST_FAST) begin
            vmax_valid <= 1'b0; // [R27]
            temp_count <= 2'b00;
            term_hit <= 1'b0;
        end else begin
            if (cell_done) begin
                if (!vmax_valid || cell_avg > vmax) begin
                    vmax <= cell_avg;
                    vmax_valid <= 1'b1;
                end
                if (vmax_valid && volt_ok) begin // [R15]
                    if (sel_peak && fell_by(vmax, cell_avg, PEAK_DROP))
                        term_hit <= 1'b1; // [R14] [R16]
                    if (sel_ndv && !holdoff
                        && fell_by(vmax, cell_avg, NDV_DROP))
                        term_hit <= 1'b1; // [R13] [R16] [R19]
                end
            end
            if (temp_done) begin
                temp_old1 <= temp_avg;
                temp_old2 <= temp_old1;
                if (temp_count != 2'b10)
                    temp_count <= temp_count + 2'b01;
                if (temp_count == 2'b10 && !holdoff && temp_above_cutoff
                    && temp_below_low_fault
                    && fell_by(temp_old2, temp_avg, TEMP_DROP))
                    term_hit <= 1'b1; // [R21] [R19]
            end
        end
    end

    // Pin drivers; released while the hold input is low
    always @(posedge mclk) begin
        if (!reset_n) begin
            current_gate <= 1'b0;
            current_gate_oe <= 1'b1;
            discharge_drive <= 1'b0;
            discharge_drive_oe <= 1'b1;
            discharge_pullup_en <= 1'b1;
            low_power <= 1'b0;
            charge_state <= ST_QUALIFY;
        end else begin
            current_gate <= next_gate; // [R24]
            current_gate_oe <= hold_n; // [R23]
            discharge_drive <= hold_n && state == ST_DISCHARGE
                && cell_above_end_discharge; // [R02]
            discharge_drive_oe <= hold_n; // [R23]
            discharge_pullup_en <= 1'b1; // [R03]
            low_power <= ~hold_n; // [R23]
            charge_state <= state;
        end
    end

    // Classic Wishbone slave, one wait state, unmapped reads return zero
    always @(posedge mclk) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl <= `CCT_CTRL_RESET;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                if (wb_we_i && wb_sel_i[0] && wb_adr_i == `CCT_REG_CTRL)
                    ctrl <= {30'h00000000,
                             wb_dat_i[`CCT_CTRL_TOPOFF_EN], 1'b0};
                case (wb_adr_i)
                    `CCT_REG_CTRL: wb_dat_o <= ctrl;
                    `CCT_REG_STATUS: wb_dat_o <= {19'h00000, sel_ndv,
                        sel_peak, ~hold_n, term_hit, holdoff, state};
                    `CCT_REG_VMAX: wb_dat_o <= {{(32-CODE_W){1'b0}}, vmax};
                    `CCT_REG_TEMP: wb_dat_o <= {{(32-CODE_W){1'b0}},
                        temp_old1};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// file: tb/cct_battery.sv
// Battery and sense network seen by the charge sequencer
module cct_battery (
    input wire mclk,
    input wire load,
    input wire [11:0] load_mv,
    input wire discharge_drive,
    output logic [11:0] cell_mv,
    output wire cell_above_max,
    output wire cell_above_end_discharge
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cell level is already taken relative to the sense reference
    assign cell_above_max = cell_mv > 12'hFA0;
    assign cell_above_end_discharge = cell_mv > 12'h7D0;
    // The discharge load pulls the cell down one code per cycle
    always @(posedge mclk) begin
        if (load) begin
            cell_mv <= load_mv;
        end else if (discharge_drive) begin
            cell_mv <= cell_mv - 12'h001;
        end
    end
endmodule

// file: tb/cct_charge_ctrl_chk.sv
// Concurrent checks on the charge sequencer pins
module cct_chk (
    input wire mclk,
    input wire reset_n,
    input wire charge_hold_n,
    input wire cell_above_max,
    input wire cell_above_end_discharge,
    input wire temp_above_high_fault,
    input wire temp_below_low_fault,
    input wire current_gate,
    input wire current_gate_oe,
    input wire discharge_drive,
    input wire discharge_drive_oe,
    input wire discharge_pullup_en,
    input wire low_power,
    input wire [7:0] charge_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_wait_gate; charge_state == 8'h20 |-> !current_gate; endproperty
    a_wait_gate: assert property (p_wait_gate)
        else $error("gate on during max-cell wait");
    property p_max_stop;
        $rose(cell_above_max) && charge_state == 8'h10 |-> ##[1:3] !current_gate;
    endproperty
    a_max_stop: assert property (p_max_stop)
        else $error("gate not cut on max cell");
    property p_hold;
        !charge_hold_n [*8] |->
            low_power && !current_gate_oe && !discharge_drive_oe;
    endproperty
    a_hold: assert property (p_hold)
        else $error("outputs not released during hold");
    property p_drv_state; discharge_drive |-> charge_state == 8'h01; endproperty
    a_drv_state: assert property (p_drv_state)
        else $error("discharge drive outside discharge state");
    // Two cycles of low cell let the comparator settle before judging
    property p_drv_end;
        (charge_state == 8'h01 && charge_hold_n && !cell_above_end_discharge)
            [*2] |-> ##[1:3] !discharge_drive;
    endproperty
    a_drv_end: assert property (p_drv_end)
        else $error("discharge not ended below end-discharge");
    property p_pullup; discharge_pullup_en; endproperty
    a_pullup: assert property (p_pullup)
        else $error("request pull-up disabled");
    property p_fast_qual;
        $rose(charge_state == 8'h10) |-> $past(cell_above_end_discharge, 2)
            && $past(temp_above_high_fault, 2) && $past(temp_below_low_fault, 2);
    endproperty
    a_fast_qual: assert property (p_fast_qual)
        else $error("fast charge entered without qualification");
    property p_absent;
        charge_state == 8'h80 |-> !current_gate && !discharge_drive;
    endproperty
    a_absent: assert property (p_absent)
        else $error("current flows with battery absent");
    c_fast: cover property (charge_state == 8'h10);
    c_discharge: cover property (discharge_drive);
    c_absent: cover property (charge_state == 8'h80);
endmodule

// file: tb/cct_charge_ctrl_bench.sv
// Self-checking bench for the charge-cycle sequencer
module cct_charge_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, discharge_request_n, charge_hold_n, load;
    logic voltage_term_select_high, voltage_term_select_low;
    logic temp_above_high_fault, temp_below_low_fault, temp_above_cutoff;
    logic wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [11:0] load_mv, temp_code;
    logic [31:0] wb_dat_i, rd;
    wire [11:0] cell_mv;
    wire [31:0] wb_dat_o;
    wire [7:0] charge_state;
    wire cell_above_max, cell_above_end_discharge, wb_ack_o, low_power;
    wire current_gate, current_gate_oe, discharge_drive, discharge_drive_oe;
    wire discharge_pullup_en;
    int error_cnt, compares, i;
    // Rows: cell above end-discharge, temp high ok, temp low ok, state
    logic [10:0] rows [4] = '{11'h710, 11'h304, 11'h504, 11'h604};
    // Modes: select high, select low, expected delta and peak bits
    logic [3:0] modes [3] = '{4'h4, 4'h2, 4'h9};
    cct_battery bat_u (.*);
    // Shortened timers keep the run brief
    cct_charge_ctrl #(
        .SAMPLE_US(32'hC350),
        .HOLDOFF_US(32'h190),
        .TOPOFF_US(32'h1E),
        .MAXCELL_WAIT_US(32'h14),
        .TRICKLE_PERIOD_US(32'h4E20)
    ) dut_u (
        .cell_code(cell_mv),
        .*
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic conclude;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic hang(logic ok);
        if (!ok) begin
            error_cnt++;
            conclude();
        end
    endtask
    task automatic wbx(logic w, logic [7:0] a, logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        wb_sel_i <= 4'hF;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 50);
        hang(wb_ack_o === 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge mclk);
    endtask
    task automatic restart;
        wbx(1'b1, 8'h00, 32'h3);
        tick(10);
    endtask
    task automatic drain;
        i = 0;
        while (discharge_drive !== 1'b0 && i < 1000) begin
            tick(1);
            i++;
        end
        hang(discharge_drive === 1'b0);
    endtask
    initial begin
        {reset_n, discharge_request_n, charge_hold_n, load} = 4'h7;
        {voltage_term_select_high, voltage_term_select_low} = 2'b00;
        {temp_above_high_fault, temp_below_low_fault} = 2'b11;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {temp_above_cutoff, temp_code, wb_sel_i} = 17'h15000;
        load_mv = 12'h9C4;
        error_cnt = 0;
        compares = 0;
        tick(16);
        chk("reset pullup", {discharge_pullup_en, charge_state}, 32'h102);
        chk("reset out", {current_gate, discharge_drive, low_power}, 32'h0);
        reset_n <= 1'b1;
        tick(1);
        wbx(1'b0, 8'h00, 32'h0);
        chk("ctrl", rd, 32'h2);
        wbx(1'b0, 8'h10, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("power-up", charge_state, 32'h10);
        foreach (rows[k]) begin
            {temp_above_high_fault, temp_below_low_fault} <= rows[k][9:8];
            load_mv <= rows[k][10] ? 12'h9C4 : 12'h708;
            restart();
            chk("qualify", charge_state, rows[k][7:0]);
        end
        tick(3100);
        chk("trickle", charge_state, 32'h08);
        temp_below_low_fault <= 1'b1;
        tick(10);
        chk("pending exit", charge_state, 32'h10);
        tick(25800);
        chk("holdoff on", current_gate, 32'h1);
        tick(400);
        chk("holdoff off", current_gate, 32'h0);
        load_mv <= 12'hFB0;
        tick(10);
        chk("max wait", {current_gate, charge_state}, 32'h20);
        load_mv <= 12'h9C4;
        tick(10);
        chk("max back", charge_state, 32'h40);
        restart();
        load_mv <= 12'hFB0;
        tick(2100);
        chk("max stays", charge_state, 32'h80);
        load_mv <= 12'h9C4;
        tick(12);
        chk("max fall", charge_state, 32'h10);
        // Request pulse from the outside party
        discharge_request_n <= 1'b0;
        tick(8);
        discharge_request_n <= 1'b1;
        load <= 1'b0;
        tick(4);
        chk("discharge", {discharge_drive, charge_state}, 32'h101);
        drain();
        tick(5);
        chk("discharged", charge_state, 32'h04);
        discharge_request_n <= 1'b0;
        tick(10);
        drain();
        load <= 1'b1;
        tick(10);
        chk("held low", charge_state, 32'h10);
        restart();
        chk("held start", {discharge_drive, charge_state}, 32'h101);
        discharge_request_n <= 1'b1;
        charge_hold_n <= 1'b0;
        tick(10);
        chk("hold", {low_power, current_gate_oe, discharge_drive_oe}, 32'h4);
        charge_hold_n <= 1'b1;
        tick(12);
        chk("hold end", {low_power, charge_state}, 32'h10);
        foreach (modes[k]) begin
            {voltage_term_select_high, voltage_term_select_low} <= modes[k][3:2];
            tick(8);
            wbx(1'b0, 8'h04, 32'h0);
            chk("mode", {rd[12:11], rd[7:0]}, {modes[k][1:0], 8'h10});
        end
        temp_above_cutoff <= 1'b0;
        tick(4);
        chk("over temp", charge_state, 32'h40);
        conclude();
    end
endmodule
bind cct_charge_ctrl cct_chk chk_u (.*);
